// ===== core/can_msg_buffer.sv
/*
 * One CAN message buffer: identifier bytes, payload bytes and length
 * code behind an APB slave, a serialiser that sends the stored frame
 * header and payload most significant bit first, and a capture port
 * that loads a received frame from the protocol engine.
 * Assumes the protocol engine pulls one bit per tx_bit_ready and
 * presents received frames as a single-cycle load strobe.
 */
// The address map and the APB register port were decided locally.
module can_msg_buffer
   import msgbuf_pkg::*;
#(
   parameter int PAYLOAD_DEPTH = 8
) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic         psel,
   input  wire logic         penable,
   input  wire logic         pwrite,
   input  wire logic [7:0]   paddr,
   input  wire logic [31:0]  pwdata,
   output logic      [31:0]  prdata,
   output logic              pready,
   output logic              pslverr,
   input  wire logic         tx_bit_ready,
   output logic              tx_bit,
   output logic              tx_bit_valid,
   output logic              tx_frame_end,
   input  wire logic         rx_load,
   input  wire logic [7:0]   rx_id_byte0,
   input  wire logic [7:0]   rx_id_byte1,
   input  wire logic [7:0]   rx_id_byte2,
   input  wire logic [7:0]   rx_id_byte3,
   input  wire logic [63:0]  rx_payload,
   input  wire logic [3:0]   rx_length_code
);

   // Elaboration check: the address map and copy logic serve eight bytes.
   if (PAYLOAD_DEPTH != 8) begin : g_depth_check
      $error("can_msg_buffer supports exactly eight payload bytes");
   end

   // Storage of the identifier bytes and length code.
   logic [7:0] id_byte0_ff;
   logic [7:0] id_byte1_ff;
   logic [7:0] id_byte2_ff;
   logic [7:0] id_byte3_ff;
   logic [3:0] length_code_ff;
   logic       rx_valid_ff;

   // Sender state.
   tx_state_t  tx_state_ff;
   logic [5:0] bit_cnt_ff;
   logic [3:0] byte_cnt_ff;
   logic [3:0] byte_total_ff;
   logic [28:0] id_shift_ff;
   logic [7:0] data_shift_ff;
   logic       data_load_ff;
   logic       data_gap_ff;
   logic       frame_end_ff;

   // APB decode.
   logic        wr_en;
   logic        rd_en;
   logic        payload_hit;
   logic [2:0]  payload_idx;
   logic        mapped;
   logic        busy;
   logic        send_req;

   assign wr_en       = psel && penable && pwrite;
   assign rd_en       = psel && penable && !pwrite;
   assign payload_hit = (paddr >= PAYLOAD0_OFS) && (paddr <= PAYLOAD7_OFS)
                        && (paddr[1:0] == 2'b00);
   assign payload_idx = 3'(paddr[4:2] - PAYLOAD0_OFS[4:2]);
   assign busy        = (tx_state_ff != TX_IDLE);
   assign send_req    = wr_en && (paddr == CONTROL_OFS)
                        && pwdata[CTRL_SEND_BIT] && !busy;

   // Address map check; unmapped addresses answer with an error.
   always_comb begin
      unique case (paddr)
         ID_BYTE0_OFS, ID_BYTE1_OFS, ID_BYTE2_OFS, ID_BYTE3_OFS,
         LENGTH_OFS, CONTROL_OFS, STATUS_OFS: mapped = 1'b1;
         default:                             mapped = payload_hit;
      endcase
   end

   // Reads of the payload memory take one wait state for the
   // registered memory port; all other accesses complete at once.
   logic rd_wait_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_wait_ff <= 1'b0;
      end else begin
         rd_wait_ff <= rd_en && payload_hit && !rd_wait_ff;
      end
   end

   assign pready  = !(rd_en && payload_hit && !rd_wait_ff);
   assign pslverr = psel && penable && pready && !mapped;

   // Payload memory shared by software, receiver and sender.
   logic       mem_we;
   logic [2:0] mem_waddr;
   logic [7:0] mem_wdata;
   logic [2:0] mem_raddr;
   logic [7:0] mem_rdata;
   logic [2:0] rx_idx_ff;
   logic       rx_copy_ff;
   logic [63:0] rx_payload_ff;

   // Received payload bytes are copied one per cycle after rx_load.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_copy_ff    <= 1'b0;
         rx_idx_ff     <= 3'h0;
         rx_payload_ff <= 64'h0;
      end else if (rx_load) begin
         rx_copy_ff    <= 1'b1;
         rx_idx_ff     <= 3'h0;
         rx_payload_ff <= rx_payload;
      end else if (rx_copy_ff) begin
         rx_idx_ff     <= 3'(rx_idx_ff + 3'h1);
         rx_payload_ff <= {8'h00, rx_payload_ff[63:8]};
         if (rx_idx_ff == 3'h7) begin
            rx_copy_ff <= 1'b0;
         end
      end
   end

   // Receiver copy takes the memory write port before software.
   always_comb begin
      if (rx_copy_ff) begin
         mem_we    = 1'b1;
         mem_waddr = rx_idx_ff;
         mem_wdata = rx_payload_ff[7:0];
      end else begin
         mem_we    = wr_en && payload_hit && !busy;
         mem_waddr = payload_idx;
         mem_wdata = pwdata[7:0];
      end
   end

   assign mem_raddr = busy ? byte_cnt_ff[2:0] : payload_idx;

   msgbuf_byte_store #(
      .DEPTH (PAYLOAD_DEPTH)
   ) u_store (
      .pclk     (pclk),
      .we       (mem_we),
      .waddr    (mem_waddr),
      .wdata    (mem_wdata),
      .raddr    (mem_raddr),
      .rdata_ff (mem_rdata)
   );

   // Identifier and length registers; a received frame wins over a
   // software write in the same cycle.  Writes are refused while sending.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         id_byte0_ff    <= BYTE_RESET;
         id_byte1_ff    <= BYTE_RESET;
         id_byte2_ff    <= BYTE_RESET;
         id_byte3_ff    <= BYTE_RESET;
         length_code_ff <= BYTE_RESET[3:0];
      end else if (rx_load) begin
         // Remote, format and substitute bits stored as received.
         id_byte0_ff    <= rx_id_byte0;
         id_byte1_ff    <= rx_id_byte1;
         id_byte2_ff    <= rx_id_byte2;
         id_byte3_ff    <= rx_id_byte3;
         length_code_ff <= rx_length_code;
      end else if (wr_en && !busy) begin
         unique case (paddr)
            ID_BYTE0_OFS: id_byte0_ff    <= pwdata[7:0];
            ID_BYTE1_OFS: id_byte1_ff    <= pwdata[7:0];
            ID_BYTE2_OFS: id_byte2_ff    <= pwdata[7:0];
            ID_BYTE3_OFS: id_byte3_ff    <= pwdata[7:0];
            LENGTH_OFS:   length_code_ff <= pwdata[DLC_MSB:0];
            default: ;
         endcase
      end
   end

   // Received-frame flag, cleared by reading status; a new frame wins.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_valid_ff <= 1'b0;
      end else if (rx_load) begin
         rx_valid_ff <= 1'b1;
      end else if (rd_en && paddr == STATUS_OFS) begin
         rx_valid_ff <= 1'b0;
      end
   end

   // Read data mux; unused bits read as zero.
   always_comb begin
      prdata = 32'h0;
      if (rd_en) begin
         unique case (paddr)
            ID_BYTE0_OFS: prdata[7:0] = id_byte0_ff;
            ID_BYTE1_OFS: prdata[7:0] = id_byte1_ff;
            ID_BYTE2_OFS: prdata[7:0] = id_byte2_ff;
            ID_BYTE3_OFS: prdata[7:0] = id_byte3_ff;
            LENGTH_OFS:   prdata[3:0] = length_code_ff;
            STATUS_OFS: begin
               prdata[STAT_BUSY_BIT] = busy;
               prdata[STAT_RXV_BIT]  = rx_valid_ff;
            end
            default:      prdata[7:0] = payload_hit ? mem_rdata : 8'h00;
         endcase
      end
   end

   // Header bits assembled from the stored bytes by format.
   logic        ext_fmt;
   logic        rtr_flag;
   logic [28:0] ident;
   logic [5:0]  hdr_bits;
   logic [3:0]  data_bytes;

   assign ext_fmt = id_byte1_ff[STD_FMT_BIT];

   always_comb begin
      if (ext_fmt) begin
         ident    = {id_byte0_ff, id_byte1_ff[7:5], id_byte1_ff[2:0],
                     id_byte2_ff, id_byte3_ff[7:1]};
         rtr_flag = id_byte3_ff[EXT_RTR_BIT];
         hdr_bits = 6'(EXT_ID_BITS);
      end else begin
         // Bytes 2 and 3 are not used in standard format.
         ident    = {18'h0, id_byte0_ff, id_byte1_ff[7:5]};
         rtr_flag = id_byte1_ff[STD_RTR_BIT];
         hdr_bits = 6'(STD_ID_BITS);
      end
   end

   // Remote frames send no data; data frames clip the count to eight.
   always_comb begin
      if (rtr_flag) begin
         data_bytes = 4'h0;
      end else if (length_code_ff > MAX_DATA_BYTES) begin
         data_bytes = MAX_DATA_BYTES;
      end else begin
         data_bytes = length_code_ff;
      end
   end

   // Sender: identifier most significant bit first, so the smaller
   // identifier keeps its dominant zeros earliest in arbitration.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_state_ff   <= TX_IDLE;
         bit_cnt_ff    <= 6'h0;
         byte_cnt_ff   <= 4'h0;
         byte_total_ff <= 4'h0;
         id_shift_ff   <= 29'h0;
         data_shift_ff <= 8'h00;
         data_load_ff  <= 1'b0;
         data_gap_ff   <= 1'b0;
         frame_end_ff  <= 1'b0;
      end else begin
         frame_end_ff <= 1'b0;
         // A gap cycle lets the memory read port see the new byte index
         // before the load takes its data; loading at once repeats a byte.
         data_gap_ff  <= 1'b0;
         data_load_ff <= data_gap_ff;
         unique case (tx_state_ff)
            TX_IDLE: begin
               if (send_req) begin
                  tx_state_ff   <= TX_ID;
                  bit_cnt_ff    <= hdr_bits;
                  byte_cnt_ff   <= 4'h0;
                  byte_total_ff <= data_bytes;
                  // Left-align so bit 28 is always the next one out.
                  id_shift_ff   <= ext_fmt ? ident
                                  : {ident[10:0], 18'h0};
               end
            end
            TX_ID: begin
               if (tx_bit_ready) begin
                  id_shift_ff <= {id_shift_ff[27:0], 1'b0};
                  bit_cnt_ff  <= 6'(bit_cnt_ff - 6'h1);
                  if (bit_cnt_ff == 6'h1) begin
                     if (byte_total_ff == 4'h0) begin
                        tx_state_ff  <= TX_IDLE;
                        frame_end_ff <= 1'b1;
                     end else begin
                        tx_state_ff  <= TX_DATA;
                        data_gap_ff  <= 1'b1;
                        bit_cnt_ff   <= 6'h0;
                     end
                  end
               end
            end
            TX_DATA: begin
               if (data_load_ff) begin
                  data_shift_ff <= mem_rdata;
                  bit_cnt_ff    <= 6'h8;
               end else if (tx_bit_ready && bit_cnt_ff != 6'h0) begin
                  data_shift_ff <= {data_shift_ff[6:0], 1'b0};
                  bit_cnt_ff    <= 6'(bit_cnt_ff - 6'h1);
                  if (bit_cnt_ff == 6'h1) begin
                     byte_cnt_ff <= 4'(byte_cnt_ff + 4'h1);
                     if (4'(byte_cnt_ff + 4'h1) == byte_total_ff) begin
                        tx_state_ff  <= TX_IDLE;
                        frame_end_ff <= 1'b1;
                     end else begin
                        data_gap_ff  <= 1'b1;
                     end
                  end
               end
            end
            default: tx_state_ff <= TX_IDLE;
         endcase
      end
   end

   // Serial outputs toward the protocol engine.
   assign tx_bit_valid = (tx_state_ff == TX_ID)
                         || (tx_state_ff == TX_DATA && !data_load_ff
                             && bit_cnt_ff != 6'h0);
   assign tx_bit       = (tx_state_ff == TX_ID) ? id_shift_ff[28]
                                                : data_shift_ff[7];
   assign tx_frame_end = frame_end_ff;

endmodule // can_msg_buffer

// ===== core/msgbuf_byte_store.sv
/*
 * Small byte memory holding the eight payload bytes of one buffer.
 * Assumes one write port and one read port in the pclk domain; read
 * data come out of a register one cycle after the address.
 */
module msgbuf_byte_store #(
   parameter int DEPTH = 8
) (
   input  wire logic                     pclk,
   input  wire logic                     we,
   input  wire logic [$clog2(DEPTH)-1:0] waddr,
   input  wire logic [7:0]               wdata,
   input  wire logic [$clog2(DEPTH)-1:0] raddr,
   output logic      [7:0]               rdata_ff
);

   logic [7:0] mem [DEPTH];

   // Write port.
   always_ff @(posedge pclk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   // Registered read port.
   always_ff @(posedge pclk) begin
      rdata_ff <= mem[raddr];
   end

endmodule // msgbuf_byte_store

// ===== pkg/msgbuf_pkg.sv
/*
 * Package for the CAN message buffer block: register offsets, field
 * positions, reset values and the frame-side constants.
 * Assumes an APB slave with 32-bit data, one aligned word per register.
 */
package msgbuf_pkg;

   // Byte addresses of the buffer registers, one word per register.
   localparam logic [7:0] ID_BYTE0_OFS   = 8'h00;
   localparam logic [7:0] ID_BYTE1_OFS   = 8'h04;
   localparam logic [7:0] ID_BYTE2_OFS   = 8'h08;
   localparam logic [7:0] ID_BYTE3_OFS   = 8'h0C;
   localparam logic [7:0] PAYLOAD0_OFS   = 8'h10;
   localparam logic [7:0] PAYLOAD7_OFS   = 8'h2C;
   localparam logic [7:0] LENGTH_OFS     = 8'h30;
   localparam logic [7:0] CONTROL_OFS    = 8'h34;
   localparam logic [7:0] STATUS_OFS     = 8'h38;

   // Field positions inside the identifier bytes and the length code.
   localparam int STD_RTR_BIT  = 4;
   localparam int STD_FMT_BIT  = 3;
   localparam int EXT_SRR_BIT  = 4;
   localparam int EXT_FMT_BIT  = 3;
   localparam int EXT_RTR_BIT  = 0;
   localparam int DLC_MSB      = 3;

   // Frame-side constants.
   localparam int STD_ID_BITS  = 11;
   localparam int EXT_ID_BITS  = 29;
   localparam logic [3:0] MAX_DATA_BYTES = 4'h8;

   // Reset value of the identifier bytes and the length code; the payload memory has no reset.
   localparam logic [7:0] BYTE_RESET   = 8'h00;

   // Control register bits.
   localparam int CTRL_SEND_BIT = 0;

   // Status register bits.
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_RXV_BIT  = 1;

   // Sender states.
   typedef enum logic [1:0] {
      TX_IDLE = 2'b00,
      TX_ID   = 2'b01,
      TX_DATA = 2'b10
   } tx_state_t;

endpackage

// ===== tb/can_engine_model.sv
/* Protocol engine model: takes serial bits, offers received frames.
   Assumes one pclk domain and a bench that calls rx_frame. */
module can_engine_model (
   input  wire logic    pclk,
   input  wire logic    presetn,
   input  wire logic    slow,
   input  wire logic    tx_bit,
   input  wire logic    tx_bit_valid,
   input  wire logic    tx_frame_end,
   output logic         tx_bit_ready,
   output logic         rx_load,
   output logic [7:0]   rx_id_byte0,
   output logic [7:0]   rx_id_byte1,
   output logic [7:0]   rx_id_byte2,
   output logic [7:0]   rx_id_byte3,
   output logic [63:0]  rx_payload,
   output logic [3:0]   rx_length_code,
   output logic [127:0] frame_bits_ff,
   output logic [6:0]   frame_len_ff
);
   timeunit 1ns;
   timeprecision 1ns;
   logic         tgl_ff;
   logic [127:0] cap_ff;
   logic [6:0]   cnt_ff;
   // Stalls every other cycle in slow mode so the sender must hold.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) tgl_ff <= 1'b0;
      else tgl_ff <= ~tgl_ff;
   end
   assign tx_bit_ready = !slow || tgl_ff;
   // Shifts in each taken bit and hands the frame over at its end.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cap_ff        <= '0;
         cnt_ff        <= '0;
         frame_bits_ff <= '0;
         frame_len_ff  <= '0;
      end else if (tx_frame_end) begin
         frame_bits_ff <= cap_ff;
         frame_len_ff  <= cnt_ff;
         cap_ff        <= '0;
         cnt_ff        <= '0;
      end else if (tx_bit_valid && tx_bit_ready) begin
         cap_ff <= {cap_ff[126:0], tx_bit};
         cnt_ff <= cnt_ff + 7'h01;
      end
   end
   // Receive lines start quiet.
   initial begin
      rx_load = 1'b0;
      {rx_id_byte0, rx_id_byte1, rx_id_byte2, rx_id_byte3} = '0;
      rx_payload = '0;
      rx_length_code = '0;
   end
   // Presents one frame for a cycle, then drives the inverse values.
   task automatic rx_frame(input logic [31:0] id, input logic [3:0] len,
                           input logic [63:0] pay);
      {rx_id_byte0, rx_id_byte1, rx_id_byte2, rx_id_byte3} <= id;
      rx_length_code <= len;
      rx_payload     <= pay;
      rx_load        <= 1'b1;
      @(posedge pclk);
      rx_load <= 1'b0;
      {rx_id_byte0, rx_id_byte1, rx_id_byte2, rx_id_byte3} <= ~id;
      rx_length_code <= ~len;
      rx_payload     <= ~pay;
   endtask
endmodule // can_engine_model

// ===== tb/msgbuf_sva.sv
/* Checker for the message buffer ports: APB timing and serial framing.
   Assumes binding to the buffer top with pclk and presetn. */
module msgbuf_sva
   import msgbuf_pkg::*;
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        tx_bit_ready,
   input wire logic        tx_bit,
   input wire logic        tx_bit_valid,
   input wire logic        tx_frame_end,
   input wire logic        rx_load
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic       busy_ff;
   logic [6:0] bits_ff;
   logic       acc, prd, start;
   // Decodes completing accesses, payload reads and accepted starts.
   assign acc = psel && penable && pready;
   assign prd = psel && !pwrite && paddr >= PAYLOAD0_OFS
                && paddr <= PAYLOAD7_OFS;
   assign start = acc && pwrite && paddr == CONTROL_OFS && pwdata[0]
                  && !busy_ff && !tx_frame_end;
   // Marks a frame in flight from its start to its end pulse.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) busy_ff <= 1'b0;
      else if (start) busy_ff <= 1'b1;
      else if (tx_frame_end) busy_ff <= 1'b0;
   end
   // Counts the bits the engine has taken in the current frame.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) bits_ff <= 7'h00;
      else if (tx_frame_end) bits_ff <= 7'h00;
      else if (tx_bit_valid && tx_bit_ready) bits_ff <= bits_ff + 7'h01;
   end
   send_start_a: assert property (start |=> tx_bit_valid)
      else $error("send did not start");
   bit_hold_a: assert property (tx_bit_valid && !tx_bit_ready |=>
      tx_bit_valid && $stable(tx_bit)) else $error("bit not held");
   end_pulse_a: assert property (tx_frame_end |->
      !tx_bit_valid ##1 !tx_frame_end) else $error("bad end pulse");
   frame_len_a: assert property (tx_frame_end |->
      (bits_ff inside {[11:75]} && bits_ff[2:0] == 3'h3) ||
      (bits_ff inside {[29:93]} && bits_ff[2:0] == 3'h5))
      else $error("bad frame bit count");
   idle_quiet_a: assert property (!busy_ff && !start |=>
      !tx_bit_valid) else $error("bit offered while idle");
   pay_wait_a: assert property (psel && !penable && prd |=>
      !pready ##1 pready) else $error("payload wait wrong");
   reg_nowait_a: assert property (psel && penable && !prd |->
      pready) else $error("register access waited");
   len_width_a: assert property (acc && !pwrite &&
      paddr == LENGTH_OFS |-> prdata[31:4] == 28'h0)
      else $error("length wider than four bits");
   unmapped_err_a: assert property (acc |-> pslverr ==
      (paddr > STATUS_OFS || paddr[1:0] != 2'b00))
      else $error("error response wrong");
   cover property (tx_frame_end && bits_ff == 7'h0B);
   cover property (tx_frame_end && bits_ff == 7'h5D);
   cover property (acc && pslverr);
   cover property (rx_load);
endmodule // msgbuf_sva

// ===== tb/testbench.sv
/* Top bench: APB register tests, transmit frames, one receive frame.
   Assumes the engine model and the checker sit beside the design. */
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import msgbuf_pkg::*;
   logic         pclk, presetn, psel, penable, pwrite, slow, err;
   logic         pready, pslverr, tx_bit_ready, tx_bit, tx_bit_valid;
   logic         tx_frame_end, rx_load;
   logic [7:0]   paddr, rx_id_byte0, rx_id_byte1, rx_id_byte2, rx_id_byte3;
   logic [31:0]  pwdata, prdata, q;
   logic [63:0]  rx_payload;
   logic [3:0]   rx_length_code;
   logic [127:0] fbits;
   logic [6:0]   flen;
   int           fail_count, samples_checked, i;
   localparam logic [31:0] RX_ID = 32'h1238_9ABD;
   logic [39:0]  frames [5] = '{40'hB4_60_00_00_02, 40'hB4_70_FF_FF_05,
      40'hD5_1D_3C_96_0F, 40'h00_1A_01_03_03, 40'h01_20_00_00_00};
   can_msg_buffer u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .tx_bit_ready(tx_bit_ready), .tx_bit(tx_bit),
      .tx_bit_valid(tx_bit_valid), .tx_frame_end(tx_frame_end),
      .rx_load(rx_load), .rx_id_byte0(rx_id_byte0),
      .rx_id_byte1(rx_id_byte1), .rx_id_byte2(rx_id_byte2),
      .rx_id_byte3(rx_id_byte3), .rx_payload(rx_payload),
      .rx_length_code(rx_length_code));
   can_engine_model eng (.pclk(pclk), .presetn(presetn), .slow(slow),
      .tx_bit(tx_bit), .tx_bit_valid(tx_bit_valid),
      .tx_frame_end(tx_frame_end), .tx_bit_ready(tx_bit_ready),
      .rx_load(rx_load), .rx_id_byte0(rx_id_byte0),
      .rx_id_byte1(rx_id_byte1), .rx_id_byte2(rx_id_byte2),
      .rx_id_byte3(rx_id_byte3), .rx_payload(rx_payload),
      .rx_length_code(rx_length_code), .frame_bits_ff(fbits),
      .frame_len_ff(flen));
   // Free-running 50 MHz clock.
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   // Reports the counts and the verdict, then stops.
   task automatic close_out();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // Compares one result and counts it.
   task automatic check(input logic [127:0] got, input logic [127:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // One APB transfer; read data and error land in q and err.
   task automatic apb(input logic [7:0] a, input logic w,
                      input logic [31:0] d);
      int   n;
      logic rdy;
      psel    <= 1'b1;
      penable <= 1'b0;
      paddr   <= a;
      pwrite  <= w;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      // The answer is taken at the rising edge that completes the access.
      do begin
         @(posedge pclk);
         rdy = pready;
         q   = prdata;
         err = pslverr;
         n++;
      end while (rdy !== 1'b1 && n < 20);
      if (rdy !== 1'b1) begin
         fail_count++;
         close_out();
      end
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   // Loads a frame, starts it and compares the bits the engine took.
   task automatic send(input logic [39:0] f);
      logic [127:0] e;
      int           n, k, t;
      e = f[27] ? {f[39:29], f[26:16], f[15:9]} : f[39:29];
      n = f[27] ? 29 : 11;
      for (k = 0; k < ((f[27] ? f[8] : f[28]) ? 0 : (f[3:0] > 8 ? 8 : f[3:0]));
           k++) begin
         e = {e[119:0], 8'hA0 + 8'(k)};
         n += 8;
      end
      for (k = 0; k < 4; k++)
         apb(ID_BYTE0_OFS + 8'(4 * k), 1'b1, {24'h0, f[39 - 8 * k -: 8]});
      apb(LENGTH_OFS, 1'b1, {28'h0, f[3:0]});
      apb(CONTROL_OFS, 1'b1, 32'h1);
      t = 0;
      do begin
         @(posedge pclk);
         t++;
      end while (tx_frame_end !== 1'b1 && t < 3000);
      if (t >= 3000) begin
         fail_count++;
         close_out();
      end
      @(posedge pclk);
      check(fbits, e);
      check(flen, n);
   endtask
   // Main sequence.
   initial begin
      {presetn, psel, penable, pwrite, slow} = '0;
      paddr = '0;
      pwdata = '0;
      fail_count = 0;
      samples_checked = 0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (i = 0; i < 4; i++) begin
         apb(ID_BYTE0_OFS + 8'(4 * i), 1'b0, 32'h0);
         check(q, 32'h0);
         apb(ID_BYTE0_OFS + 8'(4 * i), 1'b1, 32'hFFFFFF3C + i);
         apb(ID_BYTE0_OFS + 8'(4 * i), 1'b0, 32'h0);
         check(q, 32'h3C + i);
      end
      apb(LENGTH_OFS, 1'b1, 32'hFF);
      apb(LENGTH_OFS, 1'b0, 32'h0);
      check(q, 32'h0F);
      apb(8'h40, 1'b0, 32'h0);
      check({err, q}, {1'b1, 32'h0});
      for (i = 0; i < 8; i++)
         apb(PAYLOAD0_OFS + 8'(4 * i), 1'b1, 32'hA0 + i);
      for (i = 0; i < 8; i++) begin
         apb(PAYLOAD0_OFS + 8'(4 * i), 1'b0, 32'h0);
         check(q, 32'hA0 + i);
      end
      $display("test registers done");
      // Extended frames set the substitute bit in byte 1.
      for (i = 0; i < 5; i++) begin
         slow <= i[0];
         send(frames[i]);
      end
      $display("test transmit done");
      eng.rx_frame(RX_ID, 4'h7, 64'h0807060504030201);
      repeat (10) @(posedge pclk);
      apb(STATUS_OFS, 1'b0, 32'h0);
      check(q, 32'h2);
      apb(STATUS_OFS, 1'b0, 32'h0);
      check(q, 32'h0);
      for (i = 0; i < 4; i++) begin
         apb(ID_BYTE0_OFS + 8'(4 * i), 1'b0, 32'h0);
         check(q, {24'h0, RX_ID[31 - 8 * i -: 8]});
      end
      apb(LENGTH_OFS, 1'b0, 32'h0);
      check(q, 32'h7);
      for (i = 0; i < 8; i++) begin
         apb(PAYLOAD0_OFS + 8'(4 * i), 1'b0, 32'h0);
         check(q, i + 1);
      end
      $display("test receive done");
      close_out();
   end
endmodule // testbench
bind can_msg_buffer msgbuf_sva u_sva (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .tx_bit_ready(tx_bit_ready), .tx_bit(tx_bit),
   .tx_bit_valid(tx_bit_valid), .tx_frame_end(tx_frame_end),
   .rx_load(rx_load));
